// [rtl/motion_pkg.sv]
// Shared constants and carrier types for the motion pin logic
// Function
// - Busy low at most four clocks per command
// - Interrupt low while any cause active
// - System clock is input clock halved, output
// - System clock output frozen during reset
// - Constant speed drive pulses at 50% duty
// - Independent mode: plus and minus outputs
// - Pulse/direction mode: all pulses on first
// - Pulse/direction mode: second output gives direction
// - Up/down mode: first input rise counts up
// - Up/down mode: second input rise counts down
// - Reset needs running clock, held long enough
package motion_pkg;
   localparam int AXES     = 4;
   localparam int PERIOD_W = 16;
   localparam int POS_W    = 32;
   localparam int IRQ_W    = 8;

   // Busy window length in input clocks; must not exceed BUSY_MAX_CLKS
   localparam logic [2:0] BUSY_MAX_CLKS = 3'h4;
   localparam logic [2:0] BUSY_CLKS     = 3'h3;
   localparam logic [2:0] BUSY_RESET    = 3'h0;
   localparam logic       SCLK_RESET    = 1'h0;
   localparam logic       IRQ_RESET     = 1'h0;
   localparam logic [POS_W-1:0] POS_RESET = 32'h0;
   localparam logic [PERIOD_W-1:0] CNT_RESET = 16'h0;

   // Per-axis request from the profile generator
   typedef struct packed {
      logic                drive_en;
      logic                dir_minus;
      logic                pulse_dir_mode;
      logic [PERIOD_W-1:0] half_period;
   } axis_drive_t;

   typedef struct packed {
      logic plus_pulse_out;
      logic minus_pulse_or_direction_out;
   } drive_pins_t;

   typedef struct packed {
      logic phase_a_or_up_count_in;
      logic phase_b_or_down_count_in;
   } count_pins_t;
endpackage : motion_pkg

// [rtl/position_counter_in.sv]
// Count input synchroniser, decoder and real position counter for one axis
`timescale 1ns/1ps
module position_counter_in (
   input  wire logic                     clk,
   input  wire logic                     chip_reset_low,
   input  wire logic                     tick,
   input  wire logic                     updown_mode,
   input  wire motion_pkg::count_pins_t  pins,
   output logic [motion_pkg::POS_W-1:0]  real_pos
);
   typedef struct packed {
      logic [1:0]                  meta;
      logic [1:0]                  sync;
      logic [1:0]                  prev;
      logic [motion_pkg::POS_W-1:0] pos;
   } cnt_state_t;

   cnt_state_t st_q;
   cnt_state_t st_d;
   logic       up_step;
   logic       down_step;

   always_comb begin
      st_d      = st_q;
      up_step   = 1'b0;
      down_step = 1'b0;
      st_d.meta = {pins.phase_a_or_up_count_in, pins.phase_b_or_down_count_in};
      st_d.sync = st_q.meta;
      if (tick) begin
         st_d.prev = st_q.sync;
         if (updown_mode) begin
            up_step   = st_q.sync[1] & ~st_q.prev[1];
            down_step = st_q.sync[0] & ~st_q.prev[0];
         end else if ((^(st_q.sync ^ st_q.prev)) == 1'b1) begin
            // Only single-phase changes are legal steps; a double change is dropped
            up_step   = st_q.prev[0] ^ st_q.sync[1];
            down_step = ~up_step;
         end
         if (up_step && !down_step) begin
            st_d.pos = st_q.pos + 32'h1;
         end else if (down_step && !up_step) begin
            st_d.pos = st_q.pos - 32'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!chip_reset_low) begin
         st_q <= '{meta: 2'h0, sync: 2'h0, prev: 2'h0, pos: motion_pkg::POS_RESET};
      end else begin
         st_q <= st_d;
      end
   end

   assign real_pos = st_q.pos;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!chip_reset_low);

   updown_up_a: assert property (tick && updown_mode && st_q.sync == 2'h2 && st_q.prev == 2'h0
      |=> st_q.pos == $past(st_q.pos) + 32'h1) else $error("up pulse not counted");
   updown_down_a: assert property (tick && updown_mode && st_q.sync == 2'h1 && st_q.prev == 2'h0
      |=> st_q.pos == $past(st_q.pos) - 32'h1) else $error("down pulse not counted");
   quad_lead_a: assert property (tick && !updown_mode && st_q.prev == 2'h0 && st_q.sync == 2'h2
      |=> st_q.pos == $past(st_q.pos) + 32'h1) else $error("phase A lead did not count up");
   quad_lag_a: assert property (tick && !updown_mode && st_q.prev == 2'h0 && st_q.sync == 2'h1
      |=> st_q.pos == $past(st_q.pos) - 32'h1) else $error("phase B lead did not count down");
   quad_hold_a: assert property (!tick |=> $stable(st_q.pos))
      else $error("position moved off system clock tick");
   enc_down_c: cover property (tick && !updown_mode && st_q.prev == 2'h0 && st_q.sync == 2'h1);
endmodule : position_counter_in

// [rtl/motion_pins.sv]
// Host busy/interrupt pins, half-rate system clock and four axes of pulse pins
`timescale 1ns/1ps
module motion_pins (
   input  wire logic                                      clk,
   input  wire logic                                      chip_reset_low,
   input  wire logic                                      cmd_write,
   output logic                                           cmd_accept,
   output logic                                           command_busy_low,
   input  wire logic [motion_pkg::IRQ_W-1:0]              irq_cause,
   output logic                                           host_irq_low,
   output logic                                           host_irq_oe,
   output logic                                           sclk_out,
   output logic                                           sclk_tick,
   input  wire motion_pkg::axis_drive_t [motion_pkg::AXES-1:0] drive,
   input  wire logic [motion_pkg::AXES-1:0]               updown_mode,
   output motion_pkg::drive_pins_t [motion_pkg::AXES-1:0] drive_pins,
   input  wire motion_pkg::count_pins_t [motion_pkg::AXES-1:0] count_pins,
   output logic [motion_pkg::AXES-1:0][motion_pkg::POS_W-1:0] real_pos
);
   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [motion_pkg::PERIOD_W-1:0] cnt;
      logic                            phase;
      motion_pkg::drive_pins_t         pins;
   } axis_gen_t;

   typedef struct packed {
      logic                               sclk;
      logic [2:0]                         busy_cnt;
      logic                               irq;
      axis_gen_t [motion_pkg::AXES-1:0]   ax;
   } top_state_t;

   localparam axis_gen_t  AX_RESET = '{cnt: motion_pkg::CNT_RESET, phase: 1'b0, pins: 2'h0};

   top_state_t st_q;
   top_state_t st_d;
   logic       tick;
   logic       wrap;
   logic [motion_pkg::PERIOD_W:0] next_cnt;

   // Axis logic advances once per system clock period
   assign tick       = st_q.sclk;
   assign cmd_accept = cmd_write && (st_q.busy_cnt == 3'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_d     = st_q;
      wrap     = 1'b0;
      next_cnt = 17'h0;
      st_d.sclk = ~st_q.sclk;
      // Writes that land inside the busy window are dropped, not queued
      if (cmd_accept) begin
         st_d.busy_cnt = motion_pkg::BUSY_CLKS;
      end else if (st_q.busy_cnt != 3'h0) begin
         st_d.busy_cnt = st_q.busy_cnt - 3'h1;
      end
      st_d.irq = |irq_cause;
      for (int i = 0; i < motion_pkg::AXES; i++) begin
         next_cnt = {1'b0, st_q.ax[i].cnt} + 17'h1;
         wrap     = next_cnt >= {1'b0, drive[i].half_period};
         if (!drive[i].drive_en) begin
            st_d.ax[i].cnt   = motion_pkg::CNT_RESET;
            st_d.ax[i].phase = 1'b0;
         end else if (tick) begin
            // Equal high and low halves give the constant speed duty
            if (wrap) begin
               st_d.ax[i].cnt   = motion_pkg::CNT_RESET;
               st_d.ax[i].phase = ~st_q.ax[i].phase;
            end else begin
               st_d.ax[i].cnt = next_cnt[motion_pkg::PERIOD_W-1:0];
            end
         end
         if (drive[i].pulse_dir_mode) begin
            st_d.ax[i].pins.plus_pulse_out               = st_d.ax[i].phase;
            st_d.ax[i].pins.minus_pulse_or_direction_out = drive[i].dir_minus;
         end else begin
            st_d.ax[i].pins.plus_pulse_out               = st_d.ax[i].phase & ~drive[i].dir_minus;
            st_d.ax[i].pins.minus_pulse_or_direction_out = st_d.ax[i].phase & drive[i].dir_minus;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers; reset only acts on a clock edge, so a stopped clock cannot reset
   always_ff @(posedge clk) begin
      if (!chip_reset_low) begin
         st_q.sclk     <= motion_pkg::SCLK_RESET;
         st_q.busy_cnt <= motion_pkg::BUSY_RESET;
         st_q.irq      <= motion_pkg::IRQ_RESET;
         st_q.ax       <= {motion_pkg::AXES{AX_RESET}};
      end else begin
         st_q <= st_d;
      end
   end

   assign command_busy_low = (st_q.busy_cnt == 3'h0);
   assign host_irq_low     = 1'b0;
   assign host_irq_oe      = st_q.irq;
   assign sclk_out         = st_q.sclk;
   assign sclk_tick        = tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Per-axis count inputs
   for (genvar g = 0; g < motion_pkg::AXES; g++) begin : g_axis
      assign drive_pins[g] = st_q.ax[g].pins;
      position_counter_in u_cnt (
         .clk         (clk),
         .chip_reset_low      (chip_reset_low),
         .tick        (tick),
         .updown_mode (updown_mode[g]),
         .pins        (count_pins[g]),
         .real_pos    (real_pos[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!chip_reset_low);

   busy_window_a: assert property ($fell(command_busy_low)
      |-> !command_busy_low [*3] ##1 command_busy_low) else $error("busy window length wrong");
   busy_limit_a: assert property (st_q.busy_cnt <= motion_pkg::BUSY_MAX_CLKS)
      else $error("busy longer than four clocks");
   busy_drop_a: assert property (!command_busy_low |-> !cmd_accept)
      else $error("command accepted while busy");
   accept_busy_a: assert property (cmd_accept |=> !command_busy_low)
      else $error("accepted command did not raise busy");
   irq_drive_a: assert property (|irq_cause |=> host_irq_oe && !host_irq_low)
      else $error("interrupt not driven low");
   irq_release_a: assert property (irq_cause == 8'h0 |=> !host_irq_oe)
      else $error("interrupt not released");
   sclk_toggle_a: assert property ($past(chip_reset_low) |-> sclk_out != $past(sclk_out))
      else $error("system clock not at half rate");
   sclk_frozen_a: assert property (@(posedge clk) disable iff (1'b0) !chip_reset_low |=> !sclk_out)
      else $error("system clock moved during reset");

   // Reset leaves every host and axis pin idle, whatever was running before
   reset_state_a: assert property (@(posedge clk) disable iff (1'b0) !chip_reset_low
      |=> command_busy_low && !host_irq_oe && drive_pins == '0) else $error("pins not idle after reset");
   // Busy never falls by itself; only a taken command opens the window
   busy_idle_a: assert property (command_busy_low && !cmd_write |=> command_busy_low)
      else $error("busy fell without a command");
   // No second write may be taken in the three clocks after an accepted one
   accept_gap_a: assert property (cmd_accept |=> !cmd_accept [*3])
      else $error("command accepted inside busy window");

   for (genvar k = 0; k < motion_pkg::AXES; k++) begin : g_chk
      duty_half_a: assert property (tick && drive[k].drive_en && $stable(drive[k])
         && {1'b0, st_q.ax[k].cnt} + 17'h1 >= {1'b0, drive[k].half_period}
         |=> st_q.ax[k].phase != $past(st_q.ax[k].phase)) else $error("pulse half period wrong");
      indep_excl_a: assert property ($past(!drive[k].pulse_dir_mode)
         |-> !(drive_pins[k].plus_pulse_out && drive_pins[k].minus_pulse_or_direction_out))
         else $error("both pulse outputs high");
      dir_level_a: assert property (drive[k].pulse_dir_mode
         |=> drive_pins[k].minus_pulse_or_direction_out == $past(drive[k].dir_minus))
         else $error("direction output wrong");
      pd_pulse_a: assert property (drive[k].pulse_dir_mode
         |=> drive_pins[k].plus_pulse_out == st_q.ax[k].phase) else $error("pulse not on first output");
      // In independent mode the idle output stays low even while the other one pulses
      indep_plus_a: assert property ($past(!drive[k].pulse_dir_mode && !drive[k].dir_minus)
         |-> !drive_pins[k].minus_pulse_or_direction_out) else $error("minus pulse in plus direction");
      indep_minus_a: assert property ($past(!drive[k].pulse_dir_mode && drive[k].dir_minus)
         |-> !drive_pins[k].plus_pulse_out) else $error("plus pulse in minus direction");
      drive_off_a: assert property (!drive[k].drive_en |=> !drive_pins[k].plus_pulse_out)
         else $error("pulse output while drive off");
      // While the drive is on, pulse halves may only turn on a system clock tick; turning the drive off clears the phase on any clock
      phase_tick_a: assert property (!tick && drive[k].drive_en |=> $stable(st_q.ax[k].phase))
         else $error("pulse edge off system clock");
      duty_hold_a: assert property (tick && drive[k].drive_en && $stable(drive[k])
         && {1'b0, st_q.ax[k].cnt} + 17'h1 < {1'b0, drive[k].half_period}
         |=> $stable(st_q.ax[k].phase)) else $error("pulse half ended early");
   end

   busy_c: cover property (cmd_accept ##2 cmd_write && !cmd_accept);
   irq_c: cover property ($rose(host_irq_oe) ##[1:20] $fell(host_irq_oe));
   pd_pulse_c: cover property (drive[2].pulse_dir_mode && $rose(drive_pins[2].plus_pulse_out));
   minus_pulse_c: cover property (!drive[1].pulse_dir_mode && $rose(drive_pins[1].minus_pulse_or_direction_out));
endmodule : motion_pins

// [verif/count_source.sv]
// Encoder and up/down pulse source standing at the count inputs of one axis
`timescale 1ns/1ps
module count_source (
   input  wire logic                    clk,
   input  wire logic                    step,
   input  wire logic                    minus,
   input  wire logic                    updown,
   output motion_pkg::count_pins_t      pins
);
   logic [1:0] ph = 2'h0;
   logic       dir_q = 1'h0;
   int         hold = 0;

   // Pulses held 6 clocks so the device's sampler sees each one
   always @(posedge clk) begin
      if (hold > 0) hold <= hold - 1;
      if (step) begin
         dir_q <= minus;
         if (updown) hold <= 6;
         else ph <= minus ? ph - 2'h1 : ph + 2'h1;
      end
   end

   // Gray sequence 00,10,11,01 puts phase A ahead for forward steps
   always_comb begin
      if (updown) begin
         pins.phase_a_or_up_count_in   = (hold > 0) && !dir_q;
         pins.phase_b_or_down_count_in = (hold > 0) && dir_q;
      end else begin
         pins.phase_a_or_up_count_in   = ph[0] ^ ph[1];
         pins.phase_b_or_down_count_in = ph[1];
      end
   end
endmodule : count_source

// [verif/motion_pins_bench.sv]
// Self-checking bench for the motion pin logic
`timescale 1ns/1ps
module motion_pins_bench;
   typedef struct packed {logic pd; logic dm; logic [5:0] np; logic [5:0] nm;} row_t;
   localparam row_t ROWS [4] = '{'{1'h0, 1'h0, 6'h10, 6'h00}, '{1'h0, 1'h1, 6'h00, 6'h10},
                                 '{1'h1, 1'h0, 6'h10, 6'h00}, '{1'h1, 1'h1, 6'h10, 6'h20}};
   logic                                   clk = 0, chip_reset_low = 0, cmd_write = 0, step = 0, minus = 0, s;
   logic [7:0]                             irq_cause = 8'h00;
   logic [3:0]                             updown_mode = 4'h0;
   motion_pkg::axis_drive_t [3:0]          drive = '0;
   motion_pkg::drive_pins_t [3:0]          drive_pins;
   motion_pkg::count_pins_t [3:0]          count_pins;
   motion_pkg::count_pins_t                src;
   logic [3:0][31:0]                       real_pos;
   logic                                   cmd_accept, busy, irq_low, irq_oe, sclk_out, sclk_tick;
   int                                     miscompares = 0, checks = 0, cycles = 0, np, nm;

   assign count_pins = {6'h00, src};
   always #5 clk = ~clk;

   motion_pins u_motion_pins (.clk(clk), .chip_reset_low(chip_reset_low), .cmd_write(cmd_write), .cmd_accept(cmd_accept),
      .command_busy_low(busy), .irq_cause(irq_cause), .host_irq_low(irq_low), .host_irq_oe(irq_oe),
      .sclk_out(sclk_out), .sclk_tick(sclk_tick), .drive(drive), .updown_mode(updown_mode),
      .drive_pins(drive_pins), .count_pins(count_pins), .real_pos(real_pos));
   count_source u_count_source (.clk(clk), .step(step), .minus(minus), .updown(updown_mode[0]), .pins(src));

   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk

   task automatic steps(input int n, input logic m);
      for (int i = 0; i < n; i++) begin
         @(negedge clk) step = 1;
         minus = m;
         @(negedge clk) step = 0;
         repeat (12) @(negedge clk);
      end
   endtask : steps

   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   // Cuts a hang short; the whole run needs well under 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clk) chk(sclk_out === 1'b0, "system clock moved in reset");
      repeat (2) @(negedge clk);
      chip_reset_low = 1;
      @(negedge clk) s = sclk_out;
      @(negedge clk) chk(sclk_out === ~s && sclk_tick === sclk_out, "system clock not halved");
      for (int r = 0; r < 4; r++) begin
         @(negedge clk) drive[r] = '{1'h1, ROWS[r].dm, ROWS[r].pd, 16'h0002};
         repeat (6) @(negedge clk);
         np = 0;
         nm = 0;
         repeat (32) @(negedge clk) begin
            np += drive_pins[r].plus_pulse_out;
            nm += drive_pins[r].minus_pulse_or_direction_out;
         end
         chk(np == ROWS[r].np && nm == ROWS[r].nm && !$isunknown(drive_pins[r]), "drive pin pattern");
         drive[r] = '0;
      end
      @(negedge clk) cmd_write = 1;
      #1 chk(cmd_accept === 1'b1, "command not taken");
      @(negedge clk) cmd_write = 0;
      chk(busy === 1'b0, "busy missing");
      @(negedge clk) cmd_write = 1;
      #1 chk(cmd_accept === 1'b0, "command taken while busy");
      @(negedge clk) cmd_write = 0;
      chk(busy === 1'b0, "busy too short");
      @(negedge clk) chk(busy === 1'b1, "busy too long or extended");
      irq_cause = 8'h10;
      @(negedge clk) chk(irq_oe === 1'b1 && irq_low === 1'b0, "interrupt not driven");
      irq_cause = 8'h00;
      @(negedge clk) chk(irq_oe === 1'b0, "interrupt not released");
      steps(4, 0);
      chk(real_pos[0] === 32'h00000004, "encoder forward count");
      updown_mode = 4'h1;
      steps(3, 0);
      chk(real_pos[0] === 32'h00000007, "up pulse count");
      steps(2, 1);
      chk(real_pos[0] === 32'h00000005, "down pulse count");
      updown_mode = 4'h0;
      steps(4, 1);
      chk(real_pos[0] === 32'h00000001, "encoder reverse count");
      chk(real_pos[3:1] === '0, "idle axis counted");
      chip_reset_low = 0;
      repeat (5) @(negedge clk);
      chk(real_pos[0] === 32'h00000000 && sclk_out === 1'b0, "mid-run reset");
      // First command on the first edge out of reset must be taken
      chip_reset_low    = 1;
      cmd_write = 1;
      #1 chk(cmd_accept === 1'b1, "command after reset refused");
      @(negedge clk) cmd_write = 0;
      chk(busy === 1'b0 && sclk_out === 1'b1 && irq_oe === 1'b0, "state after reset release");
      repeat (3) @(negedge clk);
      chk(busy === 1'b1, "busy after reset release");
      summarize();
   end
endmodule : motion_pins_bench
